//--- verilog/sps_spi_slave_port.v
// Serial port (slave and master modes) with AHB-Lite register access
//
// The AHB-Lite slave port and the address map were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "sps_defines.vh"

module sps_spi_slave_port
#(
  parameter [7:0] MDIVP_HALF = 8'h04
)
(
  input  wire        clock_i,
  input  wire        rstn_i,
  input  wire        hsel_i,
  input  wire [31:0] haddr_i,
  input  wire [1:0]  htrans_i,
  input  wire        hwrite_i,
  input  wire [2:0]  hsize_i,
  input  wire [31:0] hwdata_i,
  input  wire        hready_i,
  output reg  [31:0] hrdata_o,
  output reg         hreadyout_o,
  output reg         hresp_o,
  input  wire        sck_i,
  output reg         sck_o,
  output reg         sck_oe_o,
  input  wire        sdi_i,
  output reg         sdo_o,
  output reg         sdo_oe_o,
  input  wire        ss_n_i,
  input  wire        sleep_i,
  output reg         wake_o
);

  // ==========================================================================
  // Pin synchronisers
  wire [2:0] pins_sync;
  wire       sck_sync;
  wire       sdi_sync;
  wire       ss_n_sync;

  // All three pins share one delay, so clock edges and data stay aligned
  sps_sync3
  #(
    .W (3)
  )
  u_sync
  (
    .clock_i (clock_i),
    .rstn_i  (rstn_i),
    .d_i     ({ss_n_i, sdi_i, sck_i}),
    .q_o     (pins_sync)
  );

  assign sck_sync  = pins_sync[0];
  assign sdi_sync  = pins_sync[1];
  assign ss_n_sync = pins_sync[2];

  // ==========================================================================
  // Software state
  reg [3:0] port_mode_field;
  reg       clock_idle_polarity;
  reg       port_enable;
  reg       write_collision;
  reg       clock_edge_select;
  reg       input_sample_phase;
  reg       buffer_full;
  reg       transfer_done_flag;
  reg       done_int_enable;
  reg       buffer_overwrite_enable;
  reg [7:0] data_buffer;

  // Engine state
  reg [7:0] serial_shift_register;
  reg [3:0] bit_count;
  reg       prev_level;
  reg       master_busy;
  reg [7:0] half_count;
  reg [4:0] toggle_count;

  // AHB data phase
  reg       dp_write;
  reg       dp_valid;
  reg [7:0] dp_addr;

  // ==========================================================================
  // Mode decode and edge detection
  wire mode_slave  = (port_mode_field == `SPS_MODE_SLV_SS) ||
                     (port_mode_field == `SPS_MODE_SLV_NOSS);
  wire mode_master = (port_mode_field == `SPS_MODE_MDIV4) ||
                     (port_mode_field == `SPS_MODE_MDIV16) ||
                     (port_mode_field == `SPS_MODE_MDIV64) ||
                     (port_mode_field == `SPS_MODE_MDIVP);
  wire ss_control  = (port_mode_field == `SPS_MODE_SLV_SS);

  // Port reset holds the bit counter at zero
  wire port_reset  = !port_enable || (ss_control && ss_n_sync);

  wire slave_active  = port_enable && mode_slave && !port_reset;
  wire master_active = port_enable && mode_master && master_busy;
  wire shift_ok      = slave_active || master_active;

  // Slave follows the pin, never its own generator
  wire clk_level  = mode_slave ? sck_sync : sck_o;
  wire level_chg  = (clk_level != prev_level);
  wire lead_edge  = level_chg && (prev_level == clock_idle_polarity);
  wire trail_edge = level_chg && (clk_level == clock_idle_polarity);

  // Edge select: set means output on trailing edge, sample on leading
  wire sample_edge = shift_ok && (clock_edge_select ? lead_edge : trail_edge);
  wire output_edge = shift_ok && (clock_edge_select ? trail_edge : lead_edge);

  wire [7:0] next_shift = {serial_shift_register[6:0], sdi_sync};
  wire       byte_done  = sample_edge && (bit_count == (`SPS_BITS_PER_BYTE - 4'h1));
  wire       busy_any   = (bit_count != 4'h0) || master_busy;

  // ==========================================================================
  // AHB-Lite access decode
  wire       ap_valid = hsel_i && htrans_i[1] && hready_i;
  wire       wr_ctrl  = dp_valid && dp_write && (dp_addr == `SPS_OFS_CTRL);
  wire       wr_stat  = dp_valid && dp_write && (dp_addr == `SPS_OFS_STAT);
  wire       wr_ctrl3 = dp_valid && dp_write && (dp_addr == `SPS_OFS_CTRL3);
  wire       wr_data  = dp_valid && dp_write && (dp_addr == `SPS_OFS_DATA);
  wire       rd_data  = ap_valid && !hwrite_i && (haddr_i[7:0] == `SPS_OFS_DATA);

  // Data writes while a byte is in flight collide and are dropped
  wire       data_collide = wr_data && busy_any;
  // An unread byte blocks a write unless overwrite is enabled
  wire       data_accept  = wr_data && !busy_any &&
                            (!buffer_full || buffer_overwrite_enable);

  reg  [31:0] next_rdata;

  always @*
  begin
    next_rdata = 32'h0000_0000;
    case (haddr_i[7:0])
      `SPS_OFS_CTRL:
      begin
        next_rdata[`SPS_CTRL_MODE_MSB:`SPS_CTRL_MODE_LSB] = port_mode_field;
        next_rdata[`SPS_CTRL_CKP_BIT]  = clock_idle_polarity;
        next_rdata[`SPS_CTRL_EN_BIT]   = port_enable;
        next_rdata[`SPS_CTRL_WRITE_COLLISION_BIT] = write_collision;
      end
      `SPS_OFS_STAT:
      begin
        next_rdata[`SPS_STAT_BF_BIT]   = buffer_full;
        next_rdata[`SPS_STAT_DONE_BIT] = transfer_done_flag;
        // Lets software confirm the idle level before enabling
        next_rdata[`SPS_STAT_SCK_BIT]  = sck_sync;
        next_rdata[`SPS_STAT_CKE_BIT]  = clock_edge_select;
        next_rdata[`SPS_STAT_SMP_BIT]  = input_sample_phase;
      end
      `SPS_OFS_CTRL3:
      begin
        next_rdata[`SPS_CTRL3_IE_BIT]   = done_int_enable;
        next_rdata[`SPS_CTRL3_BUFFER_OVERWRITE_ENABLE_BIT] = buffer_overwrite_enable;
      end
      `SPS_OFS_DATA:
        next_rdata[7:0] = data_buffer;
      default:
        next_rdata = 32'h0000_0000;
    endcase
  end

  // ==========================================================================
  // Bus slave: zero wait states, always OKAY
  always @(posedge clock_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      dp_valid    <= 1'b0;
      dp_write    <= 1'b0;
      dp_addr     <= 8'h00;
      hrdata_o    <= 32'h0000_0000;
      hreadyout_o <= 1'b1;
      hresp_o     <= 1'b0;
    end
    else
    begin
      hreadyout_o <= 1'b1;
      hresp_o     <= 1'b0;
      dp_valid    <= ap_valid;
      dp_write    <= hwrite_i;
      dp_addr     <= haddr_i[7:0];
      if (ap_valid && !hwrite_i)
        hrdata_o <= next_rdata;
    end
  end

  // ==========================================================================
  // Registers, flags and shift engine
  always @(posedge clock_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      port_mode_field         <= `SPS_RST_MODE;
      clock_idle_polarity     <= 1'b0;
      port_enable             <= 1'b0;
      write_collision         <= 1'b0;
      clock_edge_select       <= 1'b0;
      input_sample_phase      <= 1'b0;
      buffer_full             <= 1'b0;
      transfer_done_flag      <= 1'b0;
      done_int_enable         <= 1'b0;
      buffer_overwrite_enable <= 1'b0;
      data_buffer             <= `SPS_RST_DATA;
      serial_shift_register   <= `SPS_RST_DATA;
      bit_count               <= 4'h0;
      prev_level              <= 1'b0;
      sdo_o                   <= 1'b0;
    end
    else
    begin
      prev_level <= clk_level;

      if (wr_ctrl)
      begin
        port_mode_field     <= hwdata_i[`SPS_CTRL_MODE_MSB:`SPS_CTRL_MODE_LSB];
        clock_idle_polarity <= hwdata_i[`SPS_CTRL_CKP_BIT];
        port_enable         <= hwdata_i[`SPS_CTRL_EN_BIT];
      end
      if (wr_stat)
      begin
        clock_edge_select  <= hwdata_i[`SPS_STAT_CKE_BIT];
        input_sample_phase <= hwdata_i[`SPS_STAT_SMP_BIT];
      end
      if (wr_ctrl3)
      begin
        done_int_enable         <= hwdata_i[`SPS_CTRL3_IE_BIT];
        buffer_overwrite_enable <= hwdata_i[`SPS_CTRL3_BUFFER_OVERWRITE_ENABLE_BIT];
      end

      // Collision: set wins over a software clear in the same cycle
      if (data_collide)
        write_collision <= 1'b1;
      else if (wr_ctrl && !hwdata_i[`SPS_CTRL_WRITE_COLLISION_BIT])
        write_collision <= 1'b0;

      // Done flag is write-one-to-clear; a new byte wins
      if (byte_done)
        transfer_done_flag <= 1'b1;
      else if (wr_stat && hwdata_i[`SPS_STAT_DONE_BIT])
        transfer_done_flag <= 1'b0;

      // Reading the buffer clears full unless a byte lands now
      if (byte_done)
        buffer_full <= 1'b1;
      else if (rd_data)
        buffer_full <= 1'b0;

      // Software loads the next byte while the master still holds select high
      if (data_accept)
      begin
        // A write loads both buffer and shifter, MSB goes straight out
        data_buffer           <= hwdata_i[7:0];
        serial_shift_register <= hwdata_i[7:0];
        sdo_o                 <= hwdata_i[7];
        bit_count             <= 4'h0;
      end
      else if (port_reset)
        bit_count <= 4'h0;
      else if (sample_edge)
      begin
        serial_shift_register <= next_shift;
        if (byte_done)
        begin
          // Shifter keeps the received byte, so it is echoed next byte
          bit_count   <= 4'h0;
          data_buffer <= next_shift;
        end
        else
          bit_count <= bit_count + 4'h1;
      end
      else if (output_edge)
        sdo_o <= serial_shift_register[7];
    end
  end

  // ==========================================================================
  // Master clock generator; sleep halts it so the byte waits in place
  reg [7:0] half_period;

  always @*
  begin
    case (port_mode_field)
      `SPS_MODE_MDIV4:  half_period = `SPS_HALF_DIV4;
      `SPS_MODE_MDIV16: half_period = `SPS_HALF_DIV16;
      `SPS_MODE_MDIV64: half_period = `SPS_HALF_DIV64;
      `SPS_MODE_MDIVP:  half_period = MDIVP_HALF;
      default:          half_period = `SPS_HALF_DIV4;
    endcase
  end

  always @(posedge clock_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      master_busy  <= 1'b0;
      half_count   <= 8'h00;
      toggle_count <= 5'h00;
      sck_o        <= 1'b0;
    end
    else if (!port_enable || !mode_master)
    begin
      master_busy  <= 1'b0;
      half_count   <= 8'h00;
      toggle_count <= 5'h00;
      sck_o        <= clock_idle_polarity;
    end
    else if (data_accept)
    begin
      master_busy  <= 1'b1;
      half_count   <= 8'h00;
      toggle_count <= 5'h00;
    end
    else if (master_busy && !sleep_i)
    begin
      // Busy drops one clock after the last toggle, so that edge is still shifted
      if (toggle_count == `SPS_TOGGLES_BYTE)
        master_busy <= 1'b0;
      else if (half_count == half_period - 8'h01)
      begin
        half_count   <= 8'h00;
        sck_o        <= ~sck_o;
        toggle_count <= toggle_count + 5'h01;
      end
      else
        half_count <= half_count + 8'h01;
    end
  end

  // ==========================================================================
  // Pin enables and wake request
  always @(posedge clock_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      sck_oe_o <= 1'b0;
      sdo_oe_o <= 1'b0;
      wake_o   <= 1'b0;
    end
    else
    begin
      sck_oe_o <= port_enable && mode_master;
      // Release follows the synchronised select, five clocks behind the pin
      sdo_oe_o <= port_enable && ((mode_slave && !(ss_control && ss_n_sync)) ||
                                  mode_master);
      // Slave keeps shifting while asleep; a finished byte wakes the core
      wake_o   <= sleep_i && transfer_done_flag && done_int_enable;
      if (sleep_i && byte_done && done_int_enable)
        wake_o <= 1'b1;
    end
  end

endmodule

`default_nettype wire

//--- inc/sps_defines.vh
// Constants for the serial slave port: register map, fields, modes and clock dividers
// ============================================================================
`ifndef SPS_DEFINES_VH
`define SPS_DEFINES_VH

// ============================================================================
// Register offsets (byte addresses)
`define SPS_OFS_CTRL        8'h00
`define SPS_OFS_STAT        8'h04
`define SPS_OFS_CTRL3       8'h08
`define SPS_OFS_DATA        8'h0C

// ============================================================================
// Control register fields
`define SPS_CTRL_MODE_LSB   0
`define SPS_CTRL_MODE_MSB   3
`define SPS_CTRL_CKP_BIT    4
`define SPS_CTRL_EN_BIT     5
`define SPS_CTRL_WRITE_COLLISION_BIT   7

// Status register fields
`define SPS_STAT_BF_BIT     0
`define SPS_STAT_DONE_BIT   1
`define SPS_STAT_SCK_BIT    2
`define SPS_STAT_CKE_BIT    6
`define SPS_STAT_SMP_BIT    7

// Control register three fields
`define SPS_CTRL3_IE_BIT    0
`define SPS_CTRL3_BUFFER_OVERWRITE_ENABLE_BIT  4

// ============================================================================
// Reset values
`define SPS_RST_CTRL        8'h00
`define SPS_RST_MODE        4'h0
`define SPS_RST_STAT        8'h00
`define SPS_RST_CTRL3       8'h00
`define SPS_RST_DATA        8'h00

// ============================================================================
// Mode field codes
`define SPS_MODE_MDIV4      4'h0
`define SPS_MODE_MDIV16     4'h1
`define SPS_MODE_MDIV64     4'h2
`define SPS_MODE_MDIVP      4'h3
`define SPS_MODE_SLV_SS     4'h4
`define SPS_MODE_SLV_NOSS   4'h5

// ============================================================================
// Master clock half periods in system clock cycles, bits per byte and master clock toggles per byte
`define SPS_HALF_DIV4       8'h02
`define SPS_HALF_DIV16      8'h08
`define SPS_HALF_DIV64      8'h20
`define SPS_BITS_PER_BYTE   4'h8
`define SPS_TOGGLES_BYTE    5'h10

`endif

//--- verilog/sps_sync3.v
// Three-stage synchroniser with agreement filter for pin inputs
`timescale 1ns/1ps
`default_nettype none

module sps_sync3
#(
  parameter W = 1
)
(
  input  wire         clock_i,
  input  wire         rstn_i,
  input  wire [W-1:0] d_i,
  output reg  [W-1:0] q_o
);

  reg [W-1:0] s1;
  reg [W-1:0] s2;
  reg [W-1:0] s3;

  always @(posedge clock_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      s1 <= {W{1'b0}};
      s2 <= {W{1'b0}};
      s3 <= {W{1'b0}};
    end
    else
    begin
      s1 <= d_i;
      s2 <= s1;
      s3 <= s2;
    end
  end

  // ==========================================================================
  // A change is accepted only once stages two and three agree
  genvar i;
  generate
    for (i = 0; i < W; i = i + 1)
    begin : g_bit
      always @(posedge clock_i or negedge rstn_i)
      begin
        if (!rstn_i)
          q_o[i] <= 1'b0;
        else if (s2[i] == s3[i])
          q_o[i] <= s3[i];
      end
    end
  endgenerate

endmodule

`default_nettype wire

//--- tb/sps_port_sva.sv
// Port-level assertions for the serial slave port, bound to its top module
`timescale 1ns/1ps
`default_nettype none
module sps_port_sva (
  input wire logic        clock_i,
  input wire logic        rstn_i,
  input wire logic        hsel_i,
  input wire logic [31:0] haddr_i,
  input wire logic [1:0]  htrans_i,
  input wire logic        hwrite_i,
  input wire logic [31:0] hwdata_i,
  input wire logic        hready_i,
  input wire logic [31:0] hrdata_o,
  input wire logic        hreadyout_o,
  input wire logic        hresp_o,
  input wire logic        sck_oe_o,
  input wire logic        sdo_oe_o,
  input wire logic        ss_n_i,
  input wire logic        sleep_i,
  input wire logic        wake_o
);
  // ============================================================
  // Control mirror, updated at the same edge as the port itself
  logic       ctl_wr;
  logic [3:0] mode;
  logic       en;
  logic       slv;
  always_ff @(posedge clock_i or negedge rstn_i)
    if (!rstn_i)
    begin
      ctl_wr <= 1'b0;
      mode   <= 4'h0;
      en     <= 1'b0;
    end
    else
    begin
      ctl_wr <= hsel_i && htrans_i[1] && hready_i && hwrite_i && (haddr_i[7:0] == 8'h00);
      if (ctl_wr)
      begin
        mode <= hwdata_i[3:0];
        en   <= hwdata_i[5];
      end
    end
  assign slv = en && (mode == 4'h4);
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!rstn_i);
  // Seven cycles leave room for the pin synchroniser plus the output register
  a_ss_release: assert property ((slv && ss_n_i) [*7] |-> !sdo_oe_o)
    else $error("data output still driven while deselected");
  a_ss_drive: assert property ((slv && !ss_n_i) [*7] |-> sdo_oe_o)
    else $error("data output not driven while selected");
  a_free_drive: assert property ((en && mode == 4'h5) [*4] |-> sdo_oe_o)
    else $error("data output not driven without select control");
  a_off_quiet: assert property ((!en) [*3] |-> !sdo_oe_o && !sck_oe_o)
    else $error("pins driven while port disabled");
  a_slave_noclk: assert property ((en && (mode == 4'h4 || mode == 4'h5)) [*3] |-> !sck_oe_o)
    else $error("slave drives the serial clock");
  a_master_clk: assert property ((en && mode < 4'h4) [*3] |-> sck_oe_o)
    else $error("master does not drive the serial clock");
  a_wake_awake: assert property (!sleep_i |=> !wake_o)
    else $error("wake request while not asleep");
  a_bus_okay: assert property (hreadyout_o && !hresp_o)
    else $error("bus not ready or error response");
  a_read_width: assert property ($rose(hreadyout_o) || hrdata_o[31:8] == 24'h000000)
    else $error("upper read data bits not zero");
  c_wake: cover property ($rose(wake_o));
endmodule
bind sps_spi_slave_port sps_port_sva u_sva (
  .clock_i(clock_i), .rstn_i(rstn_i), .hsel_i(hsel_i), .haddr_i(haddr_i), .htrans_i(htrans_i),
  .hwrite_i(hwrite_i), .hwdata_i(hwdata_i), .hready_i(hready_i), .hrdata_o(hrdata_o),
  .hreadyout_o(hreadyout_o), .hresp_o(hresp_o), .sck_oe_o(sck_oe_o), .sdo_oe_o(sdo_oe_o),
  .ss_n_i(ss_n_i), .sleep_i(sleep_i), .wake_o(wake_o));
`default_nettype wire

//--- tb/sps_master_model.sv
// Behavioural serial bus master facing the slave port
`timescale 1ns/1ps
`default_nettype none
module sps_master_model (
  output var logic sck_o,
  output var logic data_o,
  output var logic ss_n_o,
  input wire logic data_i
);
  // ============================================================
  // Clock idles low, matching a cleared idle polarity
  int half = 80;
  // Set: slave samples on the leading edge; clear: on the trailing edge
  logic cke = 1'b1;
  initial
  begin
    sck_o  = 1'b0;
    data_o = 1'b0;
    ss_n_o = 1'b1;
  end
  task automatic sel(input logic on);
    #(half);
    ss_n_o = !on;
    #(half);
  endtask
  // With cke set the slave samples on the rising edge; its reply is read late in the high phase
  // because the slave needs several system clocks to move its output
  task automatic shift(input int n, input logic [7:0] tx, output logic [7:0] rx);
    rx = 8'h00;
    for (int i = 0; i < n; i++)
    begin
      data_o = tx[7-i];
      if (cke)
      begin
        #(half) sck_o = 1'b1;
        #(half - 2) rx = {rx[6:0], data_i};
        #2 sck_o = 1'b0;
      end
      else
      begin
        // Slave moves its output on the leading edge; read it at the end of the low phase
        sck_o = 1'b1;
        #(half) sck_o = 1'b0;
        #(half) rx = {rx[6:0], data_i};
      end
    end
    data_o = ~data_o;
  endtask
endmodule
`default_nettype wire

//--- tb/sps_spi_slave_port_tb.sv
// Self-checking testbench for the serial slave port
`timescale 1ns/1ps
`default_nettype none
module sps_spi_slave_port_tb;
  logic        clock_i;
  logic        rstn_i;
  logic        hsel_i;
  logic [31:0] haddr_i;
  logic [1:0]  htrans_i;
  logic        hwrite_i;
  logic [31:0] hwdata_i;
  wire         hready_i;
  logic [31:0] hrdata_o;
  logic        hresp_o;
  logic        sck_o;
  logic        sck_oe_o;
  logic        sdo_o;
  logic        sdo_oe_o;
  logic        sleep_i;
  logic        wake_o;
  wire         m_sck;
  wire         m_data;
  wire         ss_n;
  wire         sck_pin;
  wire         miso;
  logic [7:0]  rx;
  logic [31:0] r;
  int          num_errors = 0;
  int          cmp_count = 0;
  // A released data line shows the inverse, so stale data never matches
  assign miso    = sdo_oe_o ? sdo_o : ~sdo_o;
  assign sck_pin = sck_oe_o ? sck_o : m_sck;
  sps_spi_slave_port dut (
    .clock_i(clock_i), .rstn_i(rstn_i), .hsel_i(hsel_i), .haddr_i(haddr_i), .htrans_i(htrans_i),
    .hwrite_i(hwrite_i), .hsize_i(3'b010), .hwdata_i(hwdata_i), .hready_i(hready_i),
    .hrdata_o(hrdata_o), .hreadyout_o(hready_i), .hresp_o(hresp_o), .sck_i(sck_pin),
    .sck_o(sck_o), .sck_oe_o(sck_oe_o), .sdi_i(m_data), .sdo_o(sdo_o), .sdo_oe_o(sdo_oe_o),
    .ss_n_i(ss_n), .sleep_i(sleep_i), .wake_o(wake_o));
  sps_master_model mdl (.sck_o(m_sck), .data_o(m_data), .ss_n_o(ss_n), .data_i(miso));
  // ============================================================
  // Bus and compare helpers
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      num_errors++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d, output logic [31:0] q);
    @(posedge clock_i);
    hsel_i   <= 1'b1;
    htrans_i <= 2'b10;
    haddr_i  <= {24'h000000, a};
    hwrite_i <= w;
    do @(posedge clock_i); while (hready_i !== 1'b1);
    htrans_i <= 2'b00;
    hwdata_i <= {24'h000000, d};
    do @(posedge clock_i); while (hready_i !== 1'b1);
    q = hrdata_o;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask
  task automatic chk(input logic [7:0] a, input logic [7:0] e);
    logic [31:0] q;
    bus(1'b0, a, 8'h00, q);
    cmp(q, {24'h000000, e});
  endtask
  task automatic xfer(input logic [7:0] tx, output logic [7:0] rxd);
    mdl.sel(1'b1);
    mdl.shift(8, tx, rxd);
    mdl.sel(1'b0);
  endtask
  task automatic final_report;
    $display("errors %0d compares %0d", num_errors, cmp_count);
    if (num_errors == 0 && cmp_count > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  // ============================================================
  // Scenarios
  task automatic t_regs;
    chk(8'h00, 8'h00);
    chk(8'h04, 8'h00);
    chk(8'h08, 8'h00);
    chk(8'h0C, 8'h00);
    wr(8'h10, 8'hFF);
    chk(8'h10, 8'h00);
    wr(8'h04, 8'h40);
    wr(8'h00, 8'h24);
  endtask
  task automatic t_slave;
    wr(8'h0C, 8'hA5);
    xfer(8'h3C, rx);
    cmp({24'h000000, rx}, 32'h000000A5);
    chk(8'h04, 8'h43);
    chk(8'h0C, 8'h3C);
    chk(8'h04, 8'h42);
    wr(8'h04, 8'h42);
    chk(8'h04, 8'h40);
  endtask
  task automatic t_daisy;
    xfer(8'h5A, rx);
    cmp({24'h000000, rx}, 32'h0000003C);
    wr(8'h0C, 8'h77);
    xfer(8'h11, rx);
    cmp({24'h000000, rx}, 32'h0000005A);
    wr(8'h08, 8'h10);
    wr(8'h0C, 8'h81);
    xfer(8'h22, rx);
    cmp({24'h000000, rx}, 32'h00000081);
    wr(8'h08, 8'h00);
  endtask
  task automatic t_coll;
    mdl.sel(1'b1);
    mdl.shift(3, 8'hE0, rx);
    wr(8'h0C, 8'hFF);
    chk(8'h00, 8'hA4);
    mdl.sel(1'b0);
    repeat (8) @(posedge clock_i);
    cmp({31'h00000000, sdo_oe_o}, 32'h00000000);
    wr(8'h00, 8'h24);
    chk(8'h00, 8'h24);
    chk(8'h0C, 8'h22);
    xfer(8'h96, rx);
    chk(8'h0C, 8'h96);
  endtask
  task automatic t_sleep;
    wr(8'h08, 8'h01);
    wr(8'h04, 8'h42);
    @(posedge clock_i);
    sleep_i <= 1'b1;
    repeat (3) @(posedge clock_i);
    cmp({31'h00000000, wake_o}, 32'h00000000);
    xfer(8'h3A, rx);
    repeat (2) @(posedge clock_i);
    cmp({31'h00000000, wake_o}, 32'h00000001);
    chk(8'h0C, 8'h3A);
    sleep_i <= 1'b0;
    repeat (2) @(posedge clock_i);
    cmp({31'h00000000, wake_o}, 32'h00000000);
  endtask
  task automatic t_free;
    wr(8'h04, 8'h00);
    mdl.cke = 1'b0;
    wr(8'h00, 8'h25);
    mdl.shift(8, 8'hC3, rx);
    #(160);
    cmp({24'h000000, rx}, 32'h0000003A);
    chk(8'h0C, 8'hC3);
  endtask
  task automatic t_master;
    logic s;
    wr(8'h00, 8'h20);
    wr(8'h04, 8'h42);
    wr(8'h0C, 8'h00);
    repeat (6) @(posedge clock_i);
    sleep_i <= 1'b1;
    repeat (2) @(posedge clock_i);
    s = sck_o;
    bus(1'b0, 8'h04, 8'h00, r);
    repeat (20) @(posedge clock_i);
    cmp({31'h00000000, sck_o}, {31'h00000000, s});
    cmp({31'h00000000, r[1]}, 32'h00000000);
    sleep_i <= 1'b0;
    repeat (60) @(posedge clock_i);
    bus(1'b0, 8'h04, 8'h00, r);
    cmp({31'h00000000, r[1]}, 32'h00000001);
  endtask
  // ============================================================
  // Clock, reset, sequence and watchdog
  initial
  begin
    clock_i = 1'b0;
    forever #10 clock_i = ~clock_i;
  end
  initial
  begin
    rstn_i   = 1'b0;
    hsel_i   = 1'b0;
    haddr_i  = 32'h00000000;
    htrans_i = 2'b00;
    hwrite_i = 1'b0;
    hwdata_i = 32'h00000000;
    sleep_i  = 1'b0;
    repeat (12) @(posedge clock_i);
    rstn_i <= 1'b1;
    repeat (5) @(posedge clock_i);
    t_regs();
    t_slave();
    t_daisy();
    t_coll();
    t_sleep();
    t_free();
    t_master();
    final_report();
  end
  // Whole run needs well under 60 us; a hang ends the run as a failure
  initial
  begin
    #200000;
    num_errors++;
    final_report();
  end
endmodule
`default_nettype wire
